//--- hw/pmic_irq_pkg.sv
// Package for the interrupt status and enable block of the power device.
// Assumes a single 100 MHz clock and a byte-wide register port that is fed
// by the device's two-wire control bus engine.
// Functional notes
// - Step-down undervolt flag sets when its output falls to 66% of target.
// - Key short-press flag is set only after a 32 us input deglitch.
// - Key long-press flag, status1 bit 1, uses the same 32 us deglitch.
// - Status1 bit 0 is set when supply drops below turn-off threshold.
// - Enable2 bit 7 is read-write forced-off interrupt enable, resets to 1.
// - Enable2 bit 6 is read-write key rising-edge enable, resets to 0.
// - Enable2 bit 5 is read-write key falling-edge enable, resets to 0.
// - All status1 flags are read-only to the host and read 0 after reset.
// - Enable2 bits 4 to 0 are reserved, read-only, reading as zero.
// - Enable1 gates each status1 flag; top five reset to 1, rest to 0.
package pmic_irq_pkg;

    // Register offsets on the control bus
    localparam logic [7:0] ADDR_EN1 = 8'h28;
    localparam logic [7:0] ADDR_ST1 = 8'h29;
    localparam logic [7:0] ADDR_EN2 = 8'h2a;
    localparam logic [7:0] ADDR_ST2 = 8'h2b;

    // Status1 / enable1 bit positions
    localparam int BIT_OVERTEMP = 7;
    localparam int BIT_UV1 = 6;
    localparam int BIT_SHORT = 2;
    localparam int BIT_LONG = 1;
    localparam int BIT_SUPPLY = 0;

    // Status2 / enable2 bit positions
    localparam int BIT_FORCED = 7;
    localparam int BIT_RISE = 6;
    localparam int BIT_FALL = 5;

    // Reset values and the enable2 write mask
    localparam logic [7:0] EN1_RESET = 8'hf8;
    localparam logic [7:0] EN2_RESET = 8'h80;
    localparam logic [7:0] EN2_WMASK = 8'he0;
    localparam logic [7:0] ST_RESET = 8'h00;

    // Timing
    localparam int CLK_MHZ = 100;
    localparam int DEGLITCH_US = 32;
    localparam int DEGLITCH_CYCLES = DEGLITCH_US * CLK_MHZ;
    localparam int LONG_PRESS_MS = 1000;

    // Event pulses from the analog detectors
    typedef struct packed {
        logic overtemp;
        logic [3:0] undervolt; // [3] is channel 1, [0] is channel 4
        logic supply_low;
        logic forced_off;
    } events_t;

    // One register access from the bus engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

//--- hw/pmic_irq_status_enable.sv
// Interrupt status and enable registers with key-press detection.
// Status flags latch events and clear when the host reads them; enable
// bits gate which latched flags drive the interrupt request.
// Assumes all inputs are synchronous to clk and that event inputs are
// one-cycle pulses or levels from the analog comparators.
// The host reaches the registers through the two-wire bus engine.
`timescale 1ns/100ps
module pmic_irq_status_enable
    import pmic_irq_pkg::*;
#(
    parameter int LONG_PRESS_CYCLES = LONG_PRESS_MS * CLK_MHZ * 1000
)
(
    input wire logic clk,
    input wire logic rst,
    input wire events_t events,
    input wire logic power_key_input,
    input wire reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic irq_out
);

    // Counter end points; both counters start from zero
    localparam logic [11:0] DEGLITCH_LAST = 12'(DEGLITCH_CYCLES - 1);
    localparam logic [31:0] LONG_LAST = 32'(LONG_PRESS_CYCLES - 1);

    // Register state
    logic [7:0] en1_r;
    logic [7:0] en2_r;
    logic [7:0] st1_r;
    logic [7:0] st2_r;
    logic [7:0] st1_nxt;
    logic [7:0] st2_nxt;
    logic [7:0] rdata_nxt;
    logic irq_nxt;

    // Key filter and press timing
    logic key_db_r;
    logic [11:0] glitch_cnt_r;
    logic [31:0] hold_cnt_r;
    logic long_done_r;
    logic key_moved;
    logic deglitch_done;

    // Event strobes and access decodes
    logic key_rise;
    logic key_fall;
    logic short_evt;
    logic long_evt;
    logic rd_st1;
    logic rd_st2;
    logic wr_en1;
    logic wr_en2;

    // Address match for a write or a read
    function automatic logic hit(input reg_req_t r, input logic [7:0] a);
        hit = r.addr == a;
    endfunction

    // Any flag whose enable bit is set; used for both status registers
    function automatic logic any_enabled(input logic [7:0] flags,
        input logic [7:0] en);
        any_enabled = |(flags & en);
    endfunction

    // Key differs from its filtered level in this cycle
    assign key_moved = power_key_input != key_db_r;
    // Last cycle of an unbroken 32 us run at the new level; the filtered
    // key and both edge strobes move only here
    assign deglitch_done = key_moved && (glitch_cnt_r == DEGLITCH_LAST);

    // Deglitch counter: any return to the filtered level restarts the run,
    // so a bouncing contact never adds up time across its bounces
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            glitch_cnt_r <= 12'h000;
        end
        else if (!key_moved || deglitch_done)
        begin
            glitch_cnt_r <= 12'h000;
        end
        else
        begin
            glitch_cnt_r <= glitch_cnt_r + 12'h001;
        end
    end

    // Filtered key; resets released, matching the idle key, so no false
    // edge is reported just after reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            key_db_r <= 1'b0;
        end
        else if (deglitch_done)
        begin
            key_db_r <= power_key_input;
        end
    end

    // Edges of the filtered key; high means pressed
    // The falling edge also decides the short press
    assign key_rise = deglitch_done && power_key_input;
    assign key_fall = deglitch_done && !power_key_input;

    // Hold time of the filtered press; it stops once the long press fired
    // instead of wrapping, so a key held for minutes cannot fire twice
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hold_cnt_r <= 32'h0000_0000;
        end
        else if (!key_db_r)
        begin
            hold_cnt_r <= 32'h0000_0000;
        end
        else if (!long_done_r)
        begin
            hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
        end
    end

    // Marks a press that has already been reported as long
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            long_done_r <= 1'b0;
        end
        else if (!key_db_r)
        begin
            long_done_r <= 1'b0;
        end
        else if (long_evt)
        begin
            long_done_r <= 1'b1;
        end
    end

    // Long press fires once, on the cycle the hold count reaches its end
    assign long_evt = key_db_r && !long_done_r
        && (hold_cnt_r == LONG_LAST);
    // A release before the long threshold counts as a short press
    assign short_evt = key_fall && !long_done_r;

    // Access decodes; a strobe with a foreign offset touches nothing
    assign rd_st1 = reg_req.rd && hit(reg_req, ADDR_ST1);
    assign rd_st2 = reg_req.rd && hit(reg_req, ADDR_ST2);
    assign wr_en1 = reg_req.wr && hit(reg_req, ADDR_EN1);
    assign wr_en2 = reg_req.wr && hit(reg_req, ADDR_EN2);

    // Status1 next value: clear on read, but an event in the same cycle
    // survives the clear so the host never loses it
    always_comb
    begin
        st1_nxt = rd_st1 ? ST_RESET : st1_r;
        if (events.overtemp)
        begin
            st1_nxt[BIT_OVERTEMP] = 1'b1;
        end
        for (int i = 0; i < 4; i++)
        begin
            if (events.undervolt[3 - i])
            begin
                st1_nxt[BIT_UV1 - i] = 1'b1;
            end
        end
        if (short_evt)
        begin
            st1_nxt[BIT_SHORT] = 1'b1;
        end
        if (long_evt)
        begin
            st1_nxt[BIT_LONG] = 1'b1;
        end
        if (events.supply_low)
        begin
            st1_nxt[BIT_SUPPLY] = 1'b1;
        end
    end

    // Status2 next value, same clear-on-read rule as status1
    // Bits 4 to 0 are not modelled and stay zero
    always_comb
    begin
        st2_nxt = rd_st2 ? ST_RESET : st2_r;
        if (events.forced_off)
        begin
            st2_nxt[BIT_FORCED] = 1'b1;
        end
        if (key_rise)
        begin
            st2_nxt[BIT_RISE] = 1'b1;
        end
        if (key_fall)
        begin
            st2_nxt[BIT_FALL] = 1'b1;
        end
    end

    // Status1 register; the host cannot write it, a write to its offset
    // is simply ignored
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st1_r <= ST_RESET;
        end
        else
        begin
            st1_r <= st1_nxt;
        end
    end

    // Status2 register; the host cannot write it either
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st2_r <= ST_RESET;
        end
        else
        begin
            st2_r <= st2_nxt;
        end
    end

    // Enable1: every bit is host writable; the regulator and temperature
    // enables come out of reset set
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            en1_r <= EN1_RESET;
        end
        else if (wr_en1)
        begin
            en1_r <= reg_req.wdata;
        end
    end

    // Enable2: reserved bits are masked at the write so they read zero;
    // only the forced-off enable comes out of reset set
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            en2_r <= EN2_RESET;
        end
        else if (wr_en2)
        begin
            en2_r <= reg_req.wdata & EN2_WMASK;
        end
    end

    // Read mux; an unmapped offset reads zero, so probing is harmless
    always_comb
    begin
        unique case (reg_req.addr)
            ADDR_EN1: rdata_nxt = en1_r;
            ADDR_ST1: rdata_nxt = st1_r;
            ADDR_EN2: rdata_nxt = en2_r;
            ADDR_ST2: rdata_nxt = st2_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Read data is registered and holds until the next read strobe, so
    // the bus engine may take it late
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_req.rd)
        begin
            reg_rdata <= rdata_nxt;
        end
    end

    // Request follows the next flag state, so a clearing read drops it in
    // the same cycle as the data leaves; the host sees no stale request
    assign irq_nxt = any_enabled(st1_nxt, en1_r)
        || any_enabled(st2_nxt, en2_r);

    // Interrupt request register keeps the output free of glitches
    // from the flag and enable logic in front of it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_out <= 1'b0;
        end
        else
        begin
            irq_out <= irq_nxt;
        end
    end

endmodule

//--- verification/irq_chk.sv
// Port checker for the interrupt status and enable block.
// Assumes default enables for overtemp, undervolt and forced-off are kept.
`timescale 1ns/100ps
module irq_chk
    import pmic_irq_pkg::*;
#(
    parameter int LONG_PRESS_CYCLES = 5000
)
(
    input wire logic clk,
    input wire logic rst,
    input wire events_t events,
    input wire logic power_key_input,
    input wire reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic irq_out
);
    logic [15:0] kc_r;
    logic key_r;
    logic cause_r;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Cycles since the key last moved; saturates so it never wraps
    always_ff @(posedge clk or posedge rst)
        if (rst)
            kc_r <= 16'h0000;
        else if (power_key_input != key_r)
            kc_r <= 16'h0000;
        else if (kc_r != 16'hffff)
            kc_r <= kc_r + 16'h0001;
    // Last key level and any non-key reason for the request to rise
    always_ff @(posedge clk or posedge rst)
        if (rst)
            {key_r, cause_r} <= 2'b00;
        else
            {key_r, cause_r} <= {power_key_input, |events | reg_req.wr};
    sequence st1_rd;
        reg_req.rd && reg_req.addr == ADDR_ST1;
    endsequence
    AST_OVERTEMP_IRQ_ENABLE: assert property (events.overtemp |=> irq_out)
        else $error("overtemp gave no irq");
    AST_UV_IRQ: assert property (|events.undervolt |=> irq_out)
        else $error("undervolt gave no irq");
    AST_FORCED_IRQ: assert property (events.forced_off |=> irq_out)
        else $error("forced-off gave no irq");
    AST_UV_FLAG: assert property (events.undervolt[3] ##3 st1_rd
        |=> reg_rdata[6])
        else $error("undervolt flag lost");
    AST_SUPPLY_FLAG: assert property (events.supply_low ##3 st1_rd
        |=> reg_rdata[0])
        else $error("supply flag lost");
    AST_EN2_RSV: assert property (reg_req.rd && reg_req.addr == ADDR_EN2
        |=> reg_rdata[4:0] == 5'h00)
        else $error("reserved enable bits set");
    AST_IRQ_HOLD: assert property (irq_out && !(reg_req.rd || reg_req.wr)
        && !$past(reg_req.rd || reg_req.wr) |=> irq_out)
        else $error("irq dropped without access");
    // A key edge may only count once the deglitch span has run
    AST_IRQ_CAUSE: assert property ($rose(irq_out) |-> cause_r
        || $past(cause_r) || kc_r >= DEGLITCH_CYCLES - 8)
        else $error("irq rose without cause");
endmodule
bind pmic_irq_status_enable irq_chk #(
    .LONG_PRESS_CYCLES(LONG_PRESS_CYCLES)
) chk (.clk(clk), .rst(rst), .events(events),
    .power_key_input(power_key_input), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .irq_out(irq_out));

//--- verification/host_model.sv
// Host model: single-byte register accesses on the block's port.
// Assumes one caller at a time.
`timescale 1ns/100ps
module host_model
    import pmic_irq_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] rdata,
    output reg_req_t req
);
    initial req = '0;
    // One-cycle strobe; idle address and data flip so stale values show
    task automatic access(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        req <= '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        #1 q = rdata;
    endtask
endmodule

//--- verification/pmic_irq_status_enable_tb.sv
// Bench for the interrupt block: registers, events and key filtering.
// Assumes a shortened long-press count to keep the run brief.
`timescale 1ns/100ps
module pmic_irq_status_enable_tb
    import pmic_irq_pkg::*;
;
    logic clk;
    logic rst;
    events_t events;
    logic power_key_input;
    reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic irq_out;
    logic [7:0] q;
    int failures;
    int compares;
    pmic_irq_status_enable #(.LONG_PRESS_CYCLES(5000)) uut (.clk(clk),
        .rst(rst), .events(events), .power_key_input(power_key_input),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .irq_out(irq_out));
    host_model host (.clk(clk), .rdata(reg_rdata), .req(reg_req));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        host.access(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d, q);
    endtask
    // Key level held for n cycles, then settle past the edge
    task automatic key(input logic v, input int n);
        @(posedge clk);
        power_key_input <= v;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic finish_test;
        if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        rst = 1'b1;
        events = '0;
        power_key_input = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rc(ADDR_EN1, 8'hf8);
        rc(ADDR_ST1, 8'h00);
        rc(ADDR_EN2, 8'h80);
        wr(ADDR_EN2, 8'hff);
        rc(ADDR_EN2, 8'he0);
        wr(ADDR_ST1, 8'hff);
        rc(ADDR_ST1, 8'h00);
        wr(ADDR_EN1, 8'hff);
        rc(ADDR_EN1, 8'hff);
        wr(ADDR_EN1, 8'hf8);
        // Every event source; supply-low is masked by default
        for (int i = 0; i < 7; i++)
        begin
            @(posedge clk);
            events <= events_t'(7'h01 << i);
            @(posedge clk);
            events <= '0;
            @(posedge clk);
            #1 chk({7'h00, irq_out}, {7'h00, i != 1});
            rc(i == 0 ? ADDR_ST2 : ADDR_ST1,
                i < 2 ? 8'h80 >> (7 * i) : 8'h01 << (i + 1));
            @(posedge clk);
            #1 chk({7'h00, irq_out}, 8'h00);
        end
        key(1'b1, 100);
        key(1'b0, 3300);
        rc(ADDR_ST2, 8'h00);
        key(1'b1, 3300);
        chk({7'h00, irq_out}, 8'h01);
        rc(ADDR_ST2, 8'h40);
        key(1'b0, 3300);
        chk({7'h00, irq_out}, 8'h01);
        rc(ADDR_ST2, 8'h20);
        rc(ADDR_ST1, 8'h04);
        key(1'b1, 8500);
        rc(ADDR_ST1, 8'h02);
        finish_test;
    end
    // Run needs about 18600 cycles
    initial
    begin
        repeat (40000) @(posedge clk);
        failures++;
        finish_test;
    end
endmodule
